/* File: ige_cfg.svh */
// constants for the eight-bit i2c port expander
`ifndef IGE_CFG_SVH
`define IGE_CFG_SVH

`define IGE_ADDR_PREFIX 4'h4
`define IGE_RW_READ 1'b1

`define IGE_PTR_INPUT 2'h0
`define IGE_PTR_OUTPUT 2'h1
`define IGE_PTR_POLARITY 2'h2
`define IGE_PTR_DIRECTION 2'h3

`define IGE_OUT_RST 8'hFF
`define IGE_POL_RST 8'h00
`define IGE_DIR_RST 8'hFF
`define IGE_CAP_RST 8'hFF

`define IGE_APB_STATUS 8'h00
`define IGE_APB_MASK 8'h04
`define IGE_APB_VIEW 8'h08
`define IGE_APB_PINS 8'h0C

`define IGE_EV_W 2
`define IGE_EV_ALERT 0
`define IGE_EV_WRITE 1
`define IGE_MASK_RST 2'h0

`define IGE_SYNC_W 13
`define IGE_SYNC_RST 13'h1FFF
`define IGE_WARM_DONE 2'h3

`endif

/* File: ige_pkg.sv */
// types shared by the port expander modules
`include "ige_cfg.svh"
package ige_pkg;

	typedef enum logic [2:0] {
		IGE_IDLE,
		IGE_ADDR,
		IGE_ACK,
		IGE_PTR,
		IGE_WR,
		IGE_RD,
		IGE_RACK
	} ige_fsm_e;

	typedef struct packed {
		ige_fsm_e fsm;
		ige_fsm_e ackNext;
		logic sclPrev;
		logic sdaPrev;
		logic [7:0] shift;
		logic [2:0] bitCnt;
		logic byteFull;
		logic rw;
		logic readMore;
		logic [1:0] ptr;
		logic sdaLow;
		logic [7:0] outReg;
		logic [7:0] polReg;
		logic [7:0] dirReg;
		logic [7:0] capRaw;
		logic [1:0] warm;
		logic alertOeN;
		logic [`IGE_EV_W-1:0] status;
		logic [`IGE_EV_W-1:0] mask;
		logic irq;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} ige_state_s;

endpackage

/* File: ige_sync.sv */
// two-stage synchroniser for pins and the serial lines
`timescale 1ns/1ns
module ige_sync
	import ige_pkg::*;
#(
	parameter int WIDTH = 13,
	parameter logic [WIDTH-1:0] RST_VAL = '1
)
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} ige_sync_s;

	ige_sync_s st_r;
	ige_sync_s st_nxt;

	// first stage feeds only the second stage
	always_comb begin
		st_nxt = st_r;
		st_nxt.meta = d;
		st_nxt.stable = st_r.meta;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_r.meta <= RST_VAL;
			st_r.stable <= RST_VAL;
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	assign q = st_r.stable;

endmodule

/* File: ige_top.sv */
// eight-bit i2c port expander with an apb side window for events
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ns
`include "ige_cfg.svh"
module ige_top
	import ige_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOeN,
	input wire logic addrStrap0,
	input wire logic addrStrap1,
	input wire logic addrStrap2,
	input wire logic [7:0] expanderPinsIn,
	output logic [7:0] expanderPinsOut,
	output logic [7:0] expanderPinsOeN,
	output logic alertOut,
	output logic alertOeN
);

	logic [`IGE_SYNC_W-1:0] syncIn;
	logic [`IGE_SYNC_W-1:0] syncOut;
	logic [7:0] pinsS;
	logic sclS;
	logic sdaS;
	logic [2:0] strapS;
	ige_state_s st_r;
	ige_state_s st_nxt;

	// every outside level, scl included, crosses into sys_clk here
	assign syncIn = {addrStrap2, addrStrap1, addrStrap0, sdaIn, sclIn, expanderPinsIn};

	ige_sync #(
		.WIDTH(`IGE_SYNC_W),
		.RST_VAL(`IGE_SYNC_RST)
	) uSync (
		.sys_clk(sys_clk),
		.rst(rst),
		.ce(ce),
		.d(syncIn),
		.q(syncOut)
	);

	assign pinsS = syncOut[7:0];
	assign sclS = syncOut[8];
	assign sdaS = syncOut[9];
	assign strapS = syncOut[12:10];

	// register selected by the pointer, for serial reads only; the apb view reads the registers directly
	function automatic logic [7:0] regRead(
		input logic [1:0] sel,
		input logic [7:0] inByte,
		input logic [7:0] outV,
		input logic [7:0] polV,
		input logic [7:0] dirV
	);
		case (sel)
			`IGE_PTR_INPUT: regRead = inByte;
			`IGE_PTR_OUTPUT: regRead = outV;
			`IGE_PTR_POLARITY: regRead = polV;
			default: regRead = dirV;
		endcase
	endfunction

	// reported input byte: raw level xor polarity bit
	function automatic logic [7:0] inReport(input logic [7:0] raw, input logic [7:0] polV);
		inReport = raw ^ polV;
	endfunction

	always_comb begin
		logic sclRise;
		logic sclFall;
		logic startCond;
		logic stopCond;
		logic doLoad;
		logic addrHit;
		logic alertNow;
		logic apbSetup;
		logic apbDone;
		logic [7:0] rdByte;
		logic [7:0] newCap;
		logic [`IGE_EV_W-1:0] setEv;
		logic [`IGE_EV_W-1:0] clrEv;
		sclRise = 1'b0;
		sclFall = 1'b0;
		startCond = 1'b0;
		stopCond = 1'b0;
		doLoad = 1'b0;
		addrHit = 1'b0;
		alertNow = 1'b0;
		apbSetup = 1'b0;
		apbDone = 1'b0;
		rdByte = 8'h00;
		newCap = 8'h00;
		setEv = '0;
		clrEv = '0;
		st_nxt = st_r;

		st_nxt.sclPrev = sclS;
		st_nxt.sdaPrev = sdaS;
		sclRise = sclS & ~st_r.sclPrev;
		sclFall = ~sclS & st_r.sclPrev;
		// sda moving while scl stays high frames a transfer
		startCond = sclS & st_r.sclPrev & st_r.sdaPrev & ~sdaS;
		stopCond = sclS & st_r.sclPrev & ~st_r.sdaPrev & sdaS;
		addrHit = (st_r.shift[7:1] == {`IGE_ADDR_PREFIX, strapS});

		// synchronised pins settle two cycles after reset before the first capture
		if (st_r.warm != `IGE_WARM_DONE) begin
			st_nxt.warm = st_r.warm + 2'h1;
			if (st_r.warm == 2'h2) begin
				st_nxt.capRaw = pinsS;
			end
		end

		if (startCond) begin
			st_nxt.fsm = IGE_ADDR;
			st_nxt.bitCnt = 3'h0;
			st_nxt.byteFull = 1'b0;
			st_nxt.sdaLow = 1'b0;
		end else if (stopCond) begin
			st_nxt.fsm = IGE_IDLE;
			st_nxt.sdaLow = 1'b0;
		end else begin
			case (st_r.fsm)
				IGE_IDLE: begin
					st_nxt.sdaLow = 1'b0;
				end
				IGE_ADDR, IGE_PTR, IGE_WR: begin
					if (sclRise) begin
						st_nxt.shift = {st_r.shift[6:0], sdaS};
						st_nxt.bitCnt = st_r.bitCnt + 3'h1;
						st_nxt.byteFull = (st_r.bitCnt == 3'h7);
					end else if (sclFall && st_r.byteFull) begin
						st_nxt.byteFull = 1'b0;
						st_nxt.sdaLow = 1'b1;
						st_nxt.fsm = IGE_ACK;
						if (st_r.fsm == IGE_ADDR) begin
							// other devices' transfers leave every register alone
							if (addrHit) begin
								st_nxt.rw = st_r.shift[0];
								st_nxt.ackNext = (st_r.shift[0] == `IGE_RW_READ) ? IGE_RD : IGE_PTR;
							end else begin
								st_nxt.sdaLow = 1'b0;
								st_nxt.fsm = IGE_IDLE;
							end
						end else if (st_r.fsm == IGE_PTR) begin
							st_nxt.ptr = st_r.shift[1:0];
							st_nxt.ackNext = IGE_WR;
						end else begin
							st_nxt.ackNext = IGE_WR;
							setEv[`IGE_EV_WRITE] = 1'b1;
							// input register is read only; a write to it is acked and dropped
							case (st_r.ptr)
								`IGE_PTR_OUTPUT: st_nxt.outReg = st_r.shift;
								`IGE_PTR_POLARITY: st_nxt.polReg = st_r.shift;
								`IGE_PTR_DIRECTION: st_nxt.dirReg = st_r.shift;
								default: setEv[`IGE_EV_WRITE] = 1'b0;
							endcase
						end
					end
				end
				IGE_ACK: begin
					if (sclFall) begin
						st_nxt.sdaLow = 1'b0;
						st_nxt.bitCnt = 3'h0;
						if (st_r.ackNext == IGE_RD) begin
							doLoad = 1'b1;
						end else begin
							st_nxt.fsm = st_r.ackNext;
						end
					end
				end
				IGE_RD: begin
					if (sclFall) begin
						if (st_r.bitCnt == 3'h7) begin
							st_nxt.sdaLow = 1'b0;
							st_nxt.fsm = IGE_RACK;
						end else begin
							st_nxt.shift = {st_r.shift[6:0], 1'b0};
							st_nxt.sdaLow = ~st_r.shift[6];
							st_nxt.bitCnt = st_r.bitCnt + 3'h1;
						end
					end
				end
				IGE_RACK: begin
					if (sclRise) begin
						st_nxt.readMore = ~sdaS;
					end else if (sclFall) begin
						st_nxt.bitCnt = 3'h0;
						if (st_r.readMore) begin
							doLoad = 1'b1;
						end else begin
							st_nxt.fsm = IGE_IDLE;
						end
					end
				end
				default: begin
					st_nxt.fsm = IGE_IDLE;
					st_nxt.sdaLow = 1'b0;
				end
			endcase
		end

		// reads keep the last pointer; an input read recaptures the pins,
		// which is what clears a pending alert at the acknowledge clock
		if (doLoad) begin
			newCap = st_r.capRaw;
			if (st_r.ptr == `IGE_PTR_INPUT) begin
				newCap = pinsS;
				st_nxt.capRaw = pinsS;
			end
			rdByte = regRead(st_r.ptr, inReport(newCap, st_r.polReg),
				st_r.outReg, st_r.polReg, st_r.dirReg);
			st_nxt.shift = rdByte;
			st_nxt.sdaLow = ~rdByte[7];
			st_nxt.fsm = IGE_RD;
		end

		// only direction-one pins can alert; outputs never do
		alertNow = (|((pinsS ^ st_nxt.capRaw) & st_r.dirReg)) & (st_r.warm == `IGE_WARM_DONE);
		st_nxt.alertOeN = ~alertNow;
		setEv[`IGE_EV_ALERT] = alertNow & st_r.alertOeN;

		// apb: answer one cycle after setup, writes and read clears at completion
		apbSetup = psel & ~penable;
		apbDone = psel & penable & st_r.pready;
		st_nxt.pready = apbSetup;
		if (apbSetup) begin
			st_nxt.pslverr = 1'b0;
			case (paddr)
				`IGE_APB_STATUS: st_nxt.prdata = {30'h0, st_r.status};
				`IGE_APB_MASK: st_nxt.prdata = {30'h0, st_r.mask};
				`IGE_APB_VIEW: st_nxt.prdata = {st_r.dirReg, st_r.polReg, st_r.outReg,
					inReport(st_r.capRaw, st_r.polReg)};
				`IGE_APB_PINS: st_nxt.prdata = {20'h0, ~st_r.alertOeN, strapS, pinsS};
				default: begin
					st_nxt.prdata = 32'h0;
					st_nxt.pslverr = 1'b1;
				end
			endcase
		end
		if (apbDone) begin
			if (pwrite && paddr == `IGE_APB_MASK) begin
				st_nxt.mask = pwdata[`IGE_EV_W-1:0];
			end
			// clear only what this read returned, so nothing unseen is lost
			if (!pwrite && paddr == `IGE_APB_STATUS) begin
				clrEv = st_r.prdata[`IGE_EV_W-1:0];
			end
		end
		st_nxt.status = (st_r.status & ~clrEv) | setEv;
		st_nxt.irq = |(st_nxt.status & st_nxt.mask);
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_r <= '0;
			st_r.fsm <= IGE_IDLE;
			st_r.ackNext <= IGE_IDLE;
			st_r.sclPrev <= 1'b1;
			st_r.sdaPrev <= 1'b1;
			st_r.outReg <= `IGE_OUT_RST;
			st_r.polReg <= `IGE_POL_RST;
			st_r.dirReg <= `IGE_DIR_RST;
			st_r.capRaw <= `IGE_CAP_RST;
			st_r.alertOeN <= 1'b1;
			st_r.mask <= `IGE_MASK_RST;
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	assign prdata = st_r.prdata;
	assign pready = st_r.pready;
	assign pslverr = st_r.pslverr;
	assign irq = st_r.irq;
	assign sdaOut = st_r.rw & 1'b0;
	assign sdaOeN = ~st_r.sdaLow;
	assign expanderPinsOut = st_r.outReg;
	assign expanderPinsOeN = st_r.dirReg;
	assign alertOut = st_r.ptr[0] & 1'b0;
	assign alertOeN = st_r.alertOeN;

endmodule

/* File: ige_assertions.sv */
// assertion checker on the port expander top ports
`timescale 1ns/1ns
module ige_assertions
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic irq,
	input wire logic sclIn,
	input wire logic sdaOut,
	input wire logic sdaOeN,
	input wire logic [7:0] expanderPinsOut,
	input wire logic [7:0] expanderPinsOeN,
	input wire logic alertOut,
	input wire logic alertOeN
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	a_reset_defaults: assert property (disable iff (1'h0) rst && ce |=>
		expanderPinsOut == 8'hFF && expanderPinsOeN == 8'hFF && alertOeN && sdaOeN && !irq)
		else $error("reset values wrong");
	a_open_drain: assert property (sdaOut == 1'h0 && alertOut == 1'h0)
		else $error("open-drain line driven high");
	// sda may only move while scl is low, else it reads as start or stop
	a_ack_scl_low: assert property ($changed(sdaOeN) |-> !sclIn && !$past(sclIn))
		else $error("sda moved while scl high");
	a_out_scl_low: assert property ($changed(expanderPinsOut) |-> !sclIn && !$past(sclIn, 2))
		else $error("outputs moved outside a write");
	a_dir_scl_low: assert property ($changed(expanderPinsOeN) |-> !sclIn && !$past(sclIn, 2))
		else $error("direction moved outside a write");
	a_alert_inputs: assert property ($fell(alertOeN) |-> expanderPinsOeN != 8'h00)
		else $error("alert with no input pin");
	a_pready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("apb answer not one cycle");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("error without answer");
	cover property (!alertOeN);
	cover property ($fell(sdaOeN));
	cover property (irq);
endmodule
bind ige_top ige_assertions ige_assertions_inst (.sys_clk, .rst, .ce, .psel, .penable, .pready, .pslverr, .irq,
	.sclIn, .sdaOut, .sdaOeN, .expanderPinsOut, .expanderPinsOeN, .alertOut, .alertOeN);

/* File: ige_i2c_master.sv */
// i2c master model for the expander serial side
`timescale 1ns/1ns
module ige_i2c_master
(
	output logic scl,
	output logic sdaRel,
	input wire logic sda
);
	// extra low time to act as a slow master
	int slowNs = 0;
	initial begin
		scl = 1'h1;
		sdaRel = 1'h1;
	end
	// data moves only while scl is low
	task automatic bitIo(input logic b, output logic r);
		#31 sdaRel = b;
		#(31 + slowNs) scl = 1'h1;
		#31 r = sda;
		#32 scl = 1'h0;
	endtask
	task automatic start();
		sdaRel = 1'h1;
		#31 scl = 1'h1;
		#31 sdaRel = 1'h0;
		#63 scl = 1'h0;
	endtask
	task automatic stop();
		#31 sdaRel = 1'h0;
		#31 scl = 1'h1;
		#31 sdaRel = 1'h1;
		#32;
	endtask
	// msb first, ninth slot is the acknowledge
	task automatic byteIo(input logic [7:0] d, input logic ai, output logic [7:0] q, output logic ao);
		for (int i = 7; i >= 0; i--) begin
			bitIo(d[i], q[i]);
		end
		bitIo(ai, ao);
	endtask
endmodule

/* File: ige_tb_top.sv */
// self-checking bench for the eight-bit port expander
`timescale 1ns/1ns
`include "ige_cfg.svh"
module ige_tb_top;
	logic sys_clk = 1'h0;
	logic rst = 1'h1;
	logic ce = 1'h1;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic pready, pslverr, irq, sdaOut, sdaOeN, alertOut, alertOeN, scl, sdaRel, ackSeen, apbErr;
	logic [7:0] expanderPinsOut, expanderPinsOeN, q;
	logic [2:0] strap = 3'h5;
	logic [7:0] extPins = 8'hFF;
	// pointer, written value, value read back
	logic [23:0] rows [4] = '{24'h01A5A5, 24'h030F0F, 24'h023333, 24'h000095};
	int errors = 0;
	int check_count = 0;
	// sda has a pull-up; output pins show their driven level
	wire sdaWire = sdaRel & sdaOeN;
	wire [7:0] pinLvl = (~expanderPinsOeN & expanderPinsOut) | (expanderPinsOeN & extPins);
	always #5 sys_clk = ~sys_clk;
	ige_top ige_top_inst (.sys_clk, .rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .irq, .sclIn(scl), .sdaIn(sdaWire), .sdaOut, .sdaOeN, .addrStrap0(strap[0]),
		.addrStrap1(strap[1]), .addrStrap2(strap[2]), .expanderPinsIn(pinLvl), .expanderPinsOut,
		.expanderPinsOeN, .alertOut, .alertOeN);
	ige_i2c_master master (.scl, .sdaRel, .sda(sdaWire));
	task automatic results();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
		int n;
		@(posedge sys_clk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge sys_clk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		r = prdata;
		apbErr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (pready !== 1'h1) begin
			chk(pready, 1'h1);
			results();
		end
	endtask
	task automatic waitAlert(input logic lvl);
		int n;
		n = 0;
		while (alertOeN !== lvl && n < 200) begin
			@(posedge sys_clk);
			n++;
		end
		chk(alertOeN, lvl);
		if (n == 200) begin
			results();
		end
	endtask
	task automatic i2cWr(input logic [7:0] ab, input logic [7:0] ptr, input logic [7:0] d);
		logic [7:0] x;
		logic a;
		master.start();
		master.byteIo(ab, 1'h1, x, ackSeen);
		master.byteIo(ptr, 1'h1, x, a);
		master.byteIo(d, 1'h1, x, a);
		master.stop();
	endtask
	task automatic i2cRd(output logic [7:0] d);
		logic a;
		master.start();
		master.byteIo(8'h4B, 1'h1, d, a);
		master.byteIo(8'hFF, 1'h1, d, a);
		master.stop();
	endtask
	initial begin
		repeat (12) @(posedge sys_clk);
		rst <= 1'h0;
		repeat (4) @(posedge sys_clk);
		chk(expanderPinsOeN, 8'hFF);
		apb(1'h0, `IGE_APB_VIEW, 32'h0, rd);
		chk(rd, 32'hFF00FFFF);
		i2cWr(8'h48, 8'h01, 8'h00);
		chk(ackSeen, 1'h1);
		chk(expanderPinsOut, 8'hFF);
		@(posedge sys_clk);
		extPins <= 8'hC6;
		foreach (rows[i]) begin
			i2cWr(8'h4A, rows[i][23:16], rows[i][15:8]);
			chk(ackSeen, 1'h0);
			i2cRd(q);
			chk(q, rows[i][7:0]);
		end
		chk(expanderPinsOut, 8'hA5);
		chk(expanderPinsOeN, 8'h0F);
		apb(1'h0, `IGE_APB_VIEW, 32'h0, rd);
		chk(rd, 32'h0F33A595);
		apb(1'h1, `IGE_APB_MASK, 32'h1, rd);
		apb(1'h0, `IGE_APB_STATUS, 32'h0, rd);
		chk(rd, 32'h3);
		@(posedge sys_clk);
		extPins <= 8'hC7;
		waitAlert(1'h0);
		repeat (4) @(posedge sys_clk);
		chk(irq, 1'h1);
		apb(1'h0, `IGE_APB_STATUS, 32'h0, rd);
		chk(rd, 32'h1);
		apb(1'h0, `IGE_APB_STATUS, 32'h0, rd);
		chk(rd, 32'h0);
		chk(irq, 1'h0);
		@(posedge sys_clk);
		extPins <= 8'hC6;
		waitAlert(1'h1);
		@(posedge sys_clk);
		extPins <= 8'h46;
		repeat (20) @(posedge sys_clk);
		chk(alertOeN, 1'h1);
		extPins <= 8'h47;
		waitAlert(1'h0);
		master.slowNs = 400;
		i2cRd(q);
		chk(q, 8'h94);
		chk(alertOeN, 1'h1);
		apb(1'h0, 8'h10, 32'h0, rd);
		chk(apbErr, 1'h1);
		chk(rd, 32'h0);
		// second reset in mid-run: registers, pointer and serial engine back to defaults
		rst <= 1'h1;
		repeat (3) @(posedge sys_clk);
		rst <= 1'h0;
		repeat (4) @(posedge sys_clk);
		chk(expanderPinsOut, 8'hFF);
		chk(expanderPinsOeN, 8'hFF);
		chk(alertOeN, 1'h1);
		apb(1'h0, `IGE_APB_VIEW, 32'h0, rd);
		chk(rd, 32'hFF00FF47);
		apb(1'h0, `IGE_APB_PINS, 32'h0, rd);
		chk(rd, 32'h00000547);
		// two-byte read, master acks the first: pointer is back at input
		master.start();
		master.byteIo(8'h4B, 1'h1, q, ackSeen);
		chk(ackSeen, 1'h0);
		master.byteIo(8'hFF, 1'h0, q, ackSeen);
		chk(q, 8'h47);
		master.byteIo(8'hFF, 1'h1, q, ackSeen);
		chk(q, 8'h47);
		master.stop();
		// clock enable low freezes the synchronisers, so a pin change waits
		@(posedge sys_clk);
		ce <= 1'h0;
		extPins <= 8'h46;
		repeat (10) @(posedge sys_clk);
		chk(alertOeN, 1'h1);
		ce <= 1'h1;
		waitAlert(1'h0);
		results();
	end
endmodule
